// ===== rtl/dsm_defines.vh
`ifndef DSM_DEFINES_VH
`define DSM_DEFINES_VH

// ==========================================
// register offsets
`define DSM_ADR_STATUS_HIGH   8'h04
`define DSM_ADR_STATUS_LOW    8'h05
`define DSM_ADR_IRQ_ENABLE    8'h1F
`define DSM_ADR_PIN_SELECT    8'h21
`define DSM_ADR_SRATE_HIGH    8'h74
`define DSM_ADR_SRATE_LOW     8'h75
`define DSM_ADR_MON_HIGH      8'h7B
`define DSM_ADR_MON_LOW       8'h7C

// ==========================================
// reset values
`define DSM_RST_IRQ_ENABLE    8'h00
`define DSM_RST_PIN_SELECT    8'h14

// ==========================================
// status pin select fields
`define DSM_SEL_DESCRAMBLER   3
`define DSM_SEL_BYTE_ALIGN    2
`define DSM_SEL_CONV_DECODER  1
`define DSM_SEL_TONE          0
`define DSM_DIV_MSB           7
`define DSM_DIV_LSB           4
`define DSM_DIV_OFFSET        5'h06

// ==========================================
// monitor source selects
`define DSM_MON_CS_SYMBOL     4'h0
`define DSM_MON_DC_OFFSET     4'h1
`define DSM_MON_LOCKED_RATE   4'h3
`define DSM_MON_DECIMATION    4'h5
`define DSM_MON_FREQ_LOCK     4'h6
`define DSM_MON_TIMING_LOCK   4'h7
`define DSM_MON_PHASE_LOCK    4'h8

// ==========================================
// timing
`define DSM_CLK_HZ            50000000
`define DSM_TONE_HZ           1000
`define DSM_TONE_HALF_CYCLES  (`DSM_CLK_HZ / (2 * `DSM_TONE_HZ))
`define DSM_TWI_DEVICE_ADDR   7'h0E

`endif

// ===== rtl/dsm_regs.v
// Operation
// - status high byte at 04: SNR pair, frame, timing AGC, timing, carrier, carrier-timing, lock.
// - status low byte at 05: timing sweep bit 7, carrier sweep bit 6, rest zero.
// - read-only 16-bit symbol-rate output word, high at 116, low at 117.
// - symbol-rate word follows Rs = PLL*8192/(word+8192) scaled by decimation index.
// - monitor at 123/124 chosen by 4-bit select; select 0 shows I and Q sample.
// - select 1 shows compensated I and Q DC offsets, two's complement.
// - select 3 shows locked symbol rate in MBaud times 1024.
// - locked rate readout accurate within stated tolerance of true rate.
// - select 5 puts decimation index on monitor bits 15 to 13.
// - select 6 shows frequency lock metric byte in both monitor bytes.
// - select 7 shows timing lock metric; reading never clears it.
// - select 8 shows phase lock metric; reading leaves it unchanged.
// - other select values read as zero in both monitor bytes.
// - read-write interrupt enable byte at 31 gates events onto interrupt pin.
// - enable bits map control link down to descrambler lock, bit 7 to 0.
// - status pin is OR of lock signals selected in the byte at 33 and, with bit 0 set, the error-rate tone.
// - event flag registers clear on host read; enables only gate them.
`timescale 1ns/100ps
`include "dsm_defines.vh"
module dsm_regs #(
    parameter [6:0] DEVICE_ADDR      = `DSM_TWI_DEVICE_ADDR,
    parameter       TONE_HALF_CYCLES = `DSM_TONE_HALF_CYCLES
) (
    input  wire        CLK,
    input  wire        ARST_N,
    input  wire        SCL,
    input  wire        SDA_IN,
    output wire        SDA_OUT,
    output wire        SDA_OE,
    input  wire [1:0]  SNR_LEVEL,
    input  wire        FRAME_RECOVERY_LOCKED,
    input  wire        TIMING_AGC_LOCKED,
    input  wire        TIMING_LOCKED,
    input  wire        CARRIER_LOCKED,
    input  wire        CARRIER_TIMING_LOCKED,
    input  wire        DEMOD_LOCKED,
    input  wire        TIMING_SWEEP,
    input  wire        CARRIER_SWEEP,
    input  wire [15:0] SYMBOL_RATE_OUT,
    input  wire [3:0]  MON_SELECT,
    input  wire [7:0]  CS_SYMBOL_I,
    input  wire [7:0]  CS_SYMBOL_Q,
    input  wire [7:0]  INPHASE_OFFSET,
    input  wire [7:0]  QUADRATURE_OFFSET,
    input  wire [15:0] LOCKED_RATE_READOUT,
    input  wire [2:0]  DECIMATION_INDEX,
    input  wire [7:0]  FREQ_LOCK_METRIC,
    input  wire [15:0] TIMING_LOCK_METRIC,
    input  wire [15:0] PHASE_LOCK_METRIC,
    input  wire [7:0]  DECODER_EVENT_FLAGS,
    input  wire        DESCRAMBLER_LOCKED,
    input  wire        BYTE_ALIGN_LOCKED,
    input  wire        CONV_DECODER_LOCKED,
    output reg         IRQ_N,
    output reg         STATUS,
    output wire [3:0]  TRANSPORT_CLOCK_DIVIDER,
    output reg  [4:0]  TRANSPORT_CLOCK_RATIO,
    output reg         RD_STROBE,
    output reg  [7:0]  RD_ADDR
);
    // ==========================================
    // bus slave
    wire [7:0] ptr;
    wire       wr_stb;
    wire [7:0] wr_data;
    wire       rd_stb;
    reg  [7:0] rd_data;

    dsm_twi #(
        .DEVICE_ADDR (DEVICE_ADDR)
    ) u_twi (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .scl     (SCL),
        .sda_in  (SDA_IN),
        .sda_out (SDA_OUT),
        .sda_oe  (SDA_OE),
        .ptr     (ptr),
        .wr_stb  (wr_stb),
        .wr_data (wr_data),
        .rd_stb  (rd_stb),
        .rd_data (rd_data)
    );

    // ==========================================
    // writable registers
    reg [7:0] decoder_irq_enable;
    reg [7:0] decoder_status_pin_select;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            decoder_irq_enable        <= `DSM_RST_IRQ_ENABLE;
            decoder_status_pin_select <= `DSM_RST_PIN_SELECT;
        end else if (wr_stb) begin
            if (ptr == `DSM_ADR_IRQ_ENABLE) begin
                decoder_irq_enable <= wr_data;
            end
            if (ptr == `DSM_ADR_PIN_SELECT) begin
                decoder_status_pin_select <= wr_data;
            end
        end
    end

    assign TRANSPORT_CLOCK_DIVIDER = decoder_status_pin_select[`DSM_DIV_MSB:`DSM_DIV_LSB];

    // ==========================================
    // live status words
    wire [7:0] demod_status_high = {SNR_LEVEL, FRAME_RECOVERY_LOCKED, TIMING_AGC_LOCKED,
                                    TIMING_LOCKED, CARRIER_LOCKED, CARRIER_TIMING_LOCKED,
                                    DEMOD_LOCKED};
    wire [7:0] demod_status_low  = {TIMING_SWEEP, CARRIER_SWEEP, 6'h00};

    // ==========================================
    // monitor window, sampled every cycle so a read never disturbs a source
    reg [15:0] monitor_window;
    reg [15:0] next_monitor;

    always @* begin
        case (MON_SELECT)
            `DSM_MON_CS_SYMBOL:   next_monitor = {CS_SYMBOL_I, CS_SYMBOL_Q};
            `DSM_MON_DC_OFFSET:   next_monitor = {INPHASE_OFFSET, QUADRATURE_OFFSET};
            `DSM_MON_LOCKED_RATE: next_monitor = LOCKED_RATE_READOUT;
            `DSM_MON_DECIMATION:  next_monitor = {DECIMATION_INDEX, 13'h0000};
            `DSM_MON_FREQ_LOCK:   next_monitor = {FREQ_LOCK_METRIC, FREQ_LOCK_METRIC};
            `DSM_MON_TIMING_LOCK: next_monitor = TIMING_LOCK_METRIC;
            `DSM_MON_PHASE_LOCK:  next_monitor = PHASE_LOCK_METRIC;
            default:              next_monitor = 16'h0000;
        endcase
    end

    reg [15:0] symbol_rate_out;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            monitor_window  <= 16'h0000;
            symbol_rate_out <= 16'h0000;
        end else begin
            monitor_window  <= next_monitor;
            symbol_rate_out <= SYMBOL_RATE_OUT;
        end
    end

    // ==========================================
    // read mux: pure selection, no side effects on any source
    always @* begin
        case (ptr)
            `DSM_ADR_STATUS_HIGH: rd_data = demod_status_high;
            `DSM_ADR_STATUS_LOW:  rd_data = demod_status_low;
            `DSM_ADR_IRQ_ENABLE:  rd_data = decoder_irq_enable;
            `DSM_ADR_PIN_SELECT:  rd_data = decoder_status_pin_select;
            `DSM_ADR_SRATE_HIGH:  rd_data = symbol_rate_out[15:8];
            `DSM_ADR_SRATE_LOW:   rd_data = symbol_rate_out[7:0];
            `DSM_ADR_MON_HIGH:    rd_data = monitor_window[15:8];
            `DSM_ADR_MON_LOW:     rd_data = monitor_window[7:0];
            default:              rd_data = 8'h00;
        endcase
    end

    // read notice for the event flag registers kept elsewhere, which clear themselves on it
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RD_STROBE <= 1'b0;
            RD_ADDR   <= 8'h00;
        end else begin
            RD_STROBE <= rd_stb;
            // address only moves with its strobe, so it stays valid for the flag registers
            if (rd_stb) begin
                RD_ADDR <= ptr;
            end
        end
    end

    // ==========================================
    // error-rate tone
    wire tone;

    dsm_tone #(
        .HALF_CYCLES (TONE_HALF_CYCLES)
    ) u_tone (
        .clk    (CLK),
        .arst_n (ARST_N),
        .enable (decoder_status_pin_select[`DSM_SEL_TONE]),
        .tone   (tone)
    );

    // ==========================================
    // interrupt and status pins
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_N                 <= 1'b1;
            STATUS                <= 1'b0;
            TRANSPORT_CLOCK_RATIO <= `DSM_DIV_OFFSET;
        end else begin
            IRQ_N  <= ~|(DECODER_EVENT_FLAGS & decoder_irq_enable);
            STATUS <= (decoder_status_pin_select[`DSM_SEL_DESCRAMBLER] & DESCRAMBLER_LOCKED)
                    | (decoder_status_pin_select[`DSM_SEL_BYTE_ALIGN] & BYTE_ALIGN_LOCKED)
                    | (decoder_status_pin_select[`DSM_SEL_CONV_DECODER] & CONV_DECODER_LOCKED)
                    | tone;
            TRANSPORT_CLOCK_RATIO <= {1'b0, TRANSPORT_CLOCK_DIVIDER} + `DSM_DIV_OFFSET;
        end
    end
endmodule

// ===== rtl/dsm_tone.v
`timescale 1ns/100ps
// square wave for the error-rate tone on the status pin
module dsm_tone #(
    parameter HALF_CYCLES = 25000
) (
    input  wire clk,
    input  wire arst_n,
    input  wire enable,
    output reg  tone
);
    reg [31:0] count;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 32'h0;
            tone  <= 1'b0;
        end else if (!enable) begin
            count <= 32'h0;
            tone  <= 1'b0;
        end else if (count >= HALF_CYCLES - 1) begin
            count <= 32'h0;
            tone  <= ~tone;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

// ===== rtl/dsm_twi.v
`timescale 1ns/100ps
`include "dsm_defines.vh"
// two-wire bus slave: address byte, register pointer, auto-incremented data bytes
module dsm_twi #(
    parameter [6:0] DEVICE_ADDR = `DSM_TWI_DEVICE_ADDR
) (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       scl,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    output reg  [7:0] ptr,
    output reg        wr_stb,
    output reg  [7:0] wr_data,
    output reg        rd_stb,
    input  wire [7:0] rd_data
);
    localparam S_IDLE  = 3'h0;
    localparam S_ADDR  = 3'h1;
    localparam S_ACKA  = 3'h2;
    localparam S_REG   = 3'h3;
    localparam S_ACKW  = 3'h4;
    localparam S_WDATA = 3'h5;
    localparam S_RDATA = 3'h6;
    localparam S_RACK  = 3'h7;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] tx;
    reg       rw;
    reg       more;
    reg       scl_q;
    reg       sda_q;

    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start    = scl & scl_q & sda_q & ~sda_in;
    wire stop     = scl & scl_q & ~sda_q & sda_in;

    // open drain: the pin is only ever pulled low
    assign sda_out = 1'b0;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= S_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            tx      <= 8'h00;
            rw      <= 1'b0;
            more    <= 1'b0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            sda_oe  <= 1'b0;
            ptr     <= 8'h00;
            wr_stb  <= 1'b0;
            wr_data <= 8'h00;
            rd_stb  <= 1'b0;
        end else begin
            scl_q  <= scl;
            sda_q  <= sda_in;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (start) begin
                state   <= S_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (stop) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    S_ADDR, S_REG, S_WDATA: begin
                        shreg   <= {shreg[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    S_RDATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    S_RACK: begin
                        more <= ~sda_in;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == DEVICE_ADDR) begin
                                sda_oe <= 1'b1;
                                rw     <= shreg[0];
                                state  <= S_ACKA;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_ACKA, S_RACK: begin
                        bit_cnt <= 4'h0;
                        if (state == S_RACK && !more) begin
                            sda_oe <= 1'b0;
                            state  <= S_IDLE;
                        end else if (rw) begin
                            tx     <= rd_data;
                            rd_stb <= 1'b1;
                            sda_oe <= ~rd_data[7];
                            state  <= S_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= S_REG;
                        end
                    end
                    S_REG: begin
                        if (bit_cnt == 4'h8) begin
                            ptr    <= shreg;
                            sda_oe <= 1'b1;
                            state  <= S_ACKW;
                        end
                    end
                    S_ACKW: begin
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= S_WDATA;
                    end
                    S_WDATA: begin
                        if (bit_cnt == 4'h8) begin
                            wr_data <= shreg;
                            wr_stb  <= 1'b1;
                            sda_oe  <= 1'b1;
                            state   <= S_ACKW;
                        end
                    end
                    S_RDATA: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'b0;
                            ptr    <= ptr + 8'h01;
                            state  <= S_RACK;
                        end else begin
                            tx     <= {tx[6:0], 1'b0};
                            sda_oe <= ~tx[6];
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end else if (wr_stb) begin
                ptr <= ptr + 8'h01;
            end
        end
    end
endmodule

// ===== tb/dsm_host.sv
`timescale 1ns/100ps
module dsm_host (
    input  wire clk,
    input  wire sda,
    output reg  scl,
    output reg  sda_rel
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // ==========================================
    // bus phases of five clocks, above the four-clock minimum
    task automatic wt;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic start_cond;
        sda_rel = 1'b1;
        wt;
        scl = 1'b1;
        wt;
        sda_rel = 1'b0;
        wt;
        scl = 1'b0;
        wt;
    endtask
    task automatic stop_cond;
        sda_rel = 1'b0;
        wt;
        scl = 1'b1;
        wt;
        sda_rel = 1'b1;
        wt;
    endtask
    // eight data bits then the acknowledge bit; released means pulled high
    task automatic xfer(input [7:0] d, input ack_in, output [7:0] q, output ack);
        integer i;
        for (i = 8; i >= 0; i = i - 1) begin
            sda_rel = (i == 0) ? ack_in : d[i-1];
            wt;
            scl = 1'b1;
            wt;
            if (i == 0)
                ack = sda;
            else
                q[i-1] = sda;
            scl = 1'b0;
            wt;
        end
    endtask
endmodule

// ===== tb/dsm_regs_checker_sva.sv
`timescale 1ns/100ps
module dsm_regs_checker (
    input wire       CLK,
    input wire       ARST_N,
    input wire       SCL,
    input wire       SDA_OE,
    input wire [7:0] DECODER_EVENT_FLAGS,
    input wire       IRQ_N,
    input wire [3:0] TRANSPORT_CLOCK_DIVIDER,
    input wire [4:0] TRANSPORT_CLOCK_RATIO,
    input wire       RD_STROBE,
    input wire [7:0] RD_ADDR
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    // ==========================================
    // checks
    a_ratio_track: assert property (
        $past(ARST_N) |-> TRANSPORT_CLOCK_RATIO == $past(TRANSPORT_CLOCK_DIVIDER) + 5'h06)
        else $error("clock ratio is not divider plus six");
    a_irq_quiet: assert property (
        DECODER_EVENT_FLAGS == 8'h00 |=> IRQ_N)
        else $error("interrupt low without events");
    a_irq_cause: assert property (
        $fell(IRQ_N) |-> $past(DECODER_EVENT_FLAGS) != 8'h00)
        else $error("interrupt fell without events");
    a_strobe_pulse: assert property (
        RD_STROBE |=> !RD_STROBE)
        else $error("read strobe longer than one cycle");
    a_addr_hold: assert property (
        !RD_STROBE |-> $stable(RD_ADDR))
        else $error("read address moved without strobe");
    a_strobe_scl_low: assert property (
        RD_STROBE |-> !SCL)
        else $error("read strobe while bus clock high");
    a_div_write_only: assert property (
        !$stable(TRANSPORT_CLOCK_DIVIDER) |-> !SCL)
        else $error("divider changed outside a write");
    a_oe_hold: assert property (
        SDA_OE && SCL && $past(SCL) |=> SDA_OE)
        else $error("data released while bus clock high");
    c_mon_read: cover property (RD_STROBE && RD_ADDR == 8'h7C);
    c_irq: cover property ($fell(IRQ_N));
    c_div: cover property (!$stable(TRANSPORT_CLOCK_DIVIDER));
endmodule

bind dsm_regs dsm_regs_checker u_chk (
    .CLK(CLK), .ARST_N(ARST_N), .SCL(SCL), .SDA_OE(SDA_OE),
    .DECODER_EVENT_FLAGS(DECODER_EVENT_FLAGS), .IRQ_N(IRQ_N),
    .TRANSPORT_CLOCK_DIVIDER(TRANSPORT_CLOCK_DIVIDER), .TRANSPORT_CLOCK_RATIO(TRANSPORT_CLOCK_RATIO),
    .RD_STROBE(RD_STROBE), .RD_ADDR(RD_ADDR)
);

// ===== tb/dsm_regs_tb_top.sv
`timescale 1ns/100ps
`include "dsm_defines.vh"
module dsm_regs_tb_top;
    reg         clk;
    reg         arst_n;
    wire        scl;
    wire        sda_rel;
    wire        sda;
    wire        sda_out;
    wire        sda_oe;
    wire        irq_n;
    wire        status;
    wire [3:0]  div;
    wire [4:0]  ratio;
    wire        rd_strobe;
    wire [7:0]  rd_addr;
    integer     n_strobes;
    integer     ns0;
    reg  [7:0]  st;
    reg  [1:0]  sw;
    reg  [15:0] rate;
    reg  [3:0]  msel;
    reg  [15:0] cs;
    reg  [15:0] dco;
    reg  [15:0] lrr;
    reg  [15:0] tlm;
    reg  [15:0] plm;
    reg  [2:0]  dec;
    reg  [7:0]  flm;
    reg  [7:0]  flags;
    reg  [2:0]  lk;
    reg  [2:0]  oh;
    reg  [3:0]  dv;
    reg  [15:0] v;
    reg  [15:0] e;
    integer     i;
    integer     n_errors;
    integer     n_tests;
    integer     cycles;

    // open-drain data line with pull-up
    assign sda = sda_rel & ~(sda_oe & ~sda_out);

    dsm_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

    dsm_regs #(.TONE_HALF_CYCLES(4)) u_dut (
        .CLK(clk), .ARST_N(arst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .SNR_LEVEL(st[7:6]), .FRAME_RECOVERY_LOCKED(st[5]), .TIMING_AGC_LOCKED(st[4]),
        .TIMING_LOCKED(st[3]), .CARRIER_LOCKED(st[2]), .CARRIER_TIMING_LOCKED(st[1]),
        .DEMOD_LOCKED(st[0]), .TIMING_SWEEP(sw[1]), .CARRIER_SWEEP(sw[0]), .SYMBOL_RATE_OUT(rate),
        .MON_SELECT(msel), .CS_SYMBOL_I(cs[15:8]), .CS_SYMBOL_Q(cs[7:0]), .INPHASE_OFFSET(dco[15:8]),
        .QUADRATURE_OFFSET(dco[7:0]), .LOCKED_RATE_READOUT(lrr), .DECIMATION_INDEX(dec),
        .FREQ_LOCK_METRIC(flm), .TIMING_LOCK_METRIC(tlm), .PHASE_LOCK_METRIC(plm),
        .DECODER_EVENT_FLAGS(flags), .DESCRAMBLER_LOCKED(lk[2]), .BYTE_ALIGN_LOCKED(lk[1]),
        .CONV_DECODER_LOCKED(lk[0]), .IRQ_N(irq_n), .STATUS(status), .TRANSPORT_CLOCK_DIVIDER(div),
        .TRANSPORT_CLOCK_RATIO(ratio), .RD_STROBE(rd_strobe), .RD_ADDR(rd_addr)
    );

    always @(posedge clk) begin
        if (rd_strobe === 1'b1)
            n_strobes = n_strobes + 1;
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================
    // checking and bus tasks
    task automatic chk(input string nm, input [15:0] x, input [15:0] g);
        n_tests = n_tests + 1;
        if (g !== x) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        reg [7:0] q;
        reg [2:0] k;
        u_host.start_cond;
        u_host.xfer({`DSM_TWI_DEVICE_ADDR, 1'b0}, 1'b1, q, k[2]);
        u_host.xfer(a, 1'b1, q, k[1]);
        u_host.xfer(d, 1'b1, q, k[0]);
        u_host.stop_cond;
        chk("write ack", 16'h0000, {13'h0, k});
    endtask
    // two bytes from a, the second through the auto-increment
    task automatic rd2(input [7:0] a, output [15:0] r);
        reg [7:0] q;
        reg [3:0] k;
        u_host.start_cond;
        u_host.xfer({`DSM_TWI_DEVICE_ADDR, 1'b0}, 1'b1, q, k[3]);
        u_host.xfer(a, 1'b1, q, k[2]);
        u_host.start_cond;
        u_host.xfer({`DSM_TWI_DEVICE_ADDR, 1'b1}, 1'b1, q, k[1]);
        u_host.xfer(8'hFF, 1'b0, r[15:8], k[0]);
        u_host.xfer(8'hFF, 1'b1, r[7:0], k[0]);
        u_host.stop_cond;
        chk("read ack", 16'h0000, {13'h0, k[3:1]});
    endtask
    task test_done;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            n_errors = n_errors + 1;
            $display("MISMATCH timeout expected finish seen hang");
            test_done;
        end
    end

    // ==========================================
    // main sequence
    initial begin
        n_errors = 0;
        n_tests = 0;
        n_strobes = 0;
        cycles = 0;
        arst_n = 1'b0;
        {st, sw, rate, msel, flags, lk} = 0;
        cs = 16'h1234;
        dco = 16'hFD03;
        lrr = 16'h5A3C;
        dec = 3'h5;
        flm = 8'h9E;
        tlm = 16'hC001;
        plm = 16'h0FF0;
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        settle;
        chk("divider reset", 16'h0001, {12'h0, div});
        chk("ratio reset", 16'h0007, {11'h0, ratio});
        rd2(`DSM_ADR_IRQ_ENABLE, v);
        chk("irq enable reset", 16'h0000, v);
        rd2(`DSM_ADR_PIN_SELECT, v);
        chk("pin select reset", 16'h1400, v);
        wr(`DSM_ADR_STATUS_HIGH, 8'h00);
        wr(`DSM_ADR_SRATE_HIGH, 8'h00);
        st = 8'hA6;
        sw = 2'b10;
        rate = 16'hA5C3;
        ns0 = n_strobes;
        rd2(`DSM_ADR_STATUS_HIGH, v);
        chk("status bytes", 16'hA680, v);
        chk("read strobes", 16'h0002, 16'(n_strobes - ns0));
        chk("read address", 16'h0005, {8'h00, rd_addr});
        rd2(`DSM_ADR_SRATE_HIGH, v);
        chk("symbol rate", 16'hA5C3, v);
        for (i = 0; i < 10; i = i + 1) begin
            msel = i;
            rd2(`DSM_ADR_MON_HIGH, v);
            case (i)
                0: e = cs;
                1: e = dco;
                3: e = lrr;
                5: e = {dec, 13'h0};
                6: e = {flm, flm};
                7: e = tlm;
                8: e = plm;
                default: e = 16'h0000;
            endcase
            chk("monitor", e, (i == 5) ? (v & 16'hE000) : v);
            if (i == 3)
                chk("rate setting bits", {2'b00, lrr[15:2]}, v >> 2);
        end
        for (i = 0; i < 8; i = i + 1) begin
            wr(`DSM_ADR_IRQ_ENABLE, 8'h01 << i);
            flags = ~(8'h01 << i);
            settle;
            chk("irq masked", 16'h0001, {15'h0, irq_n});
            flags = 8'h01 << i;
            settle;
            chk("irq raised", 16'h0000, {15'h0, irq_n});
            flags = 8'h00;
        end
        rd2(`DSM_ADR_IRQ_ENABLE, v);
        chk("irq enable readback", 16'h8000, v);
        for (i = 0; i < 4; i = i + 1) begin
            oh = (i < 3) ? (3'b100 >> i) : 3'b000;
            dv = i * 5;
            wr(`DSM_ADR_PIN_SELECT, {dv, oh, 1'b0});
            lk = ~oh;
            settle;
            chk("status pin off", 16'h0000, {15'h0, status});
            lk = (i == 3) ? 3'b111 : oh;
            settle;
            chk("status pin on", (i < 3) ? 16'h0001 : 16'h0000, {15'h0, status});
            chk("divider", {12'h0, dv}, {12'h0, div});
            chk("ratio", {12'h0, dv} + 16'h0006, {11'h0, ratio});
        end
        rd2(`DSM_ADR_PIN_SELECT, v);
        chk("pin select readback", 16'hF000, v);
        wr(`DSM_ADR_PIN_SELECT, 8'h01);
        lk = 3'b000;
        settle;
        e = {15'h0, status};
        repeat (4) @(posedge clk);
        #1;
        chk("status tone", e ^ 16'h0001, {15'h0, status});
        arst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        settle;
        chk("divider reset again", 16'h0001, {12'h0, div});
        chk("status reset", 16'h0000, {15'h0, status});
        rd2(`DSM_ADR_PIN_SELECT, v);
        chk("pin select reset again", 16'h1400, v);
        test_done;
    end
endmodule
